// file: usd_consts.svh
// Purpose: Constants of the shadow data port: addresses, reset values, depths.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef USD_CONSTS_SVH
`define USD_CONSTS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define USD_SHADOW6_ADDR 32'h5000_1048
`define USD_SHADOW_BASE 32'h5000_1030
`define USD_SHADOW_LAST 32'h5000_106C
`define USD_ADDR_ALIGN_MASK 32'h0000_0003

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define USD_DATA_MSB 7
`define USD_DATA_RESET 8'h00
`define USD_UPPER_ZERO 24'h00_0000
`define USD_HRDATA_RESET 32'h0000_0000

// ****************************************************************
// Depths
// ****************************************************************
`define USD_FIFO_WORDS 32
`define USD_LEVEL_W 6
`define USD_CFG_DEPTH 6'h10

`endif

// file: usd_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock; level counts stored words at once.
// Notes: Head data shows valid one cycle after it is written.
`timescale 1ns/1ps
`default_nettype none

module usd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Fill side.
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side.
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    // Fill level.
    output logic [AW:0] level
);
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW-1:0] rdAddr;
    logic [AW:0] level_next;
    logic push;
    logic pop;

    assign inReady = (level != (AW+1)'(DEPTH));
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign rdAddr = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    assign level_next = level + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            level <= '0;
        end else begin
            wrPtr_reg <= push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
            rdPtr_reg <= rdAddr;
            level <= level_next;
        end
    end

    // A word written where the head is read is not in the read register yet.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outValid <= 1'b0;
        end else begin
            outValid <= (level_next != '0) && !(push && wrPtr_reg == rdAddr);
        end
    end

    usd_mem #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk(clk),
        .wrEn(push),
        .wrAddr(wrPtr_reg),
        .wrData(inData),
        .rdAddr(rdAddr),
        .rdData(outData)
    );
endmodule : usd_fifo

`default_nettype wire

// file: usd_line_model.sv
// Purpose: Line-side partner of the shadow port, standing for framing.
// Assumes: One clock; the bench calls send once for each received byte.
// Notes: Idle receive bytes show the inverse of the last byte each line carried.
`timescale 1ns/1ps
`default_nettype none

module usd_line_model (
    // Clock, reset and stall control.
    input wire logic clk,
    input wire logic rstn,
    input wire logic stall,
    // Received bytes towards the port.
    output logic serRxValid,
    output var usd_pkg::usd_byte_t serRxByte,
    output logic irRxValid,
    output var usd_pkg::usd_byte_t irRxByte,
    // Bytes to transmit from the port.
    input wire usd_pkg::usd_byte_t txByte,
    input wire logic txSerValid,
    input wire logic txIrValid,
    output logic txReady,
    // Report of each byte taken.
    output logic takenValid,
    output logic takenIr,
    output var usd_pkg::usd_byte_t takenByte
);
    import usd_pkg::*;

    initial begin
        serRxValid = 1'b0;
        irRxValid = 1'b0;
        serRxByte = 8'h00;
        irRxByte = 8'hFF;
    end

    // Both lines fire at once; the unselected one carries the inverse.
    // A port that listens to the wrong line then reads a wrong byte.
    task automatic send(input usd_byte_t b, input logic ir,
            input logic more);
        serRxValid <= 1'b1;
        irRxValid <= 1'b1;
        serRxByte <= ir ? ~b : b;
        irRxByte <= ir ? b : ~b;
        @(posedge clk);
        if (!more) begin
            serRxValid <= 1'b0;
            irRxValid <= 1'b0;
            serRxByte <= ~serRxByte;
            irRxByte <= ~irRxByte;
        end
    endtask : send

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txReady <= 1'b0;
            takenValid <= 1'b0;
            takenIr <= 1'b0;
            takenByte <= 8'h00;
        end else begin
            txReady <= !stall;
            takenValid <= (txSerValid || txIrValid) && txReady;
            takenIr <= txIrValid;
            takenByte <= txByte;
        end
    end
endmodule : usd_line_model

`default_nettype wire

// file: usd_mem.sv
// Purpose: Small word memory with one write port and a registered read port.
// Assumes: Read of a location written in the same cycle returns the old word.
// Notes: Contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module usd_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port.
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdData <= store[rdAddr];
    end
endmodule : usd_mem

`default_nettype wire

// file: usd_pkg.sv
// Purpose: Types shared by the shadow data port files.
// Assumes: Nothing.
// Notes: Constants live in usd_consts.svh.
`default_nettype none

package usd_pkg;
    typedef logic [7:0] usd_byte_t;
    typedef logic [1:0] usd_trans_t;
endpackage : usd_pkg

`default_nettype wire

// file: usd_shadow_port.sv
// Purpose: Shadow receive and transmit data port of a UART on AHB-Lite.
// Assumes: Framing, line status and FIFO control logic sit outside.
// Notes: Status outputs lag the internal state by one clock.
`include "usd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module usd_shadow_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire usd_pkg::usd_trans_t htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Mode controls.
    input wire logic fifoEnable,
    input wire logic irMode,
    // Received characters from the framing logic.
    input wire logic serRxValid,
    input wire usd_pkg::usd_byte_t serRxByte,
    input wire logic irRxValid,
    input wire usd_pkg::usd_byte_t irRxByte,
    // Characters to the transmit framing logic.
    output usd_pkg::usd_byte_t txByte,
    output logic txSerValid,
    output logic txIrValid,
    input wire logic txReady,
    // Line status contributions.
    output logic rxDataReady,
    output logic txHoldingEmpty,
    output logic overrunPulse
);
    import usd_pkg::*;

    // ****************************************************************
    // Address phase decode
    // ****************************************************************
    logic mapped;
    logic rdAccept;
    logic wrAccept;
    logic wrPend_reg;
    logic wrCommit;

    // Every aligned word of the window is the same register.
    function automatic logic inWindow(input logic [31:0] addr);
        inWindow = (addr >= `USD_SHADOW_BASE) && (addr <= `USD_SHADOW_LAST)
            && ((addr & `USD_ADDR_ALIGN_MASK) == 32'h0000_0000);
    endfunction : inWindow

    assign mapped = hsel && htrans[1] && hready && inWindow(haddr);
    assign rdAccept = mapped && !hwrite;
    assign wrAccept = mapped && hwrite;
    assign wrCommit = wrPend_reg && hready;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
        end else if (hready) begin
            wrPend_reg <= wrAccept;
        end
    end

    // ****************************************************************
    // Receive path
    // ****************************************************************
    logic rxIn;
    usd_byte_t rxInByte;
    usd_byte_t rxHold_reg;
    logic rxHoldValid_reg;
    logic rxFifoValid;
    usd_byte_t rxFifoData;
    logic [`USD_LEVEL_W-1:0] rxLevel;
    logic rxRoom;
    logic rxPush;
    logic rxPop;
    usd_byte_t headByte;

    assign rxIn = irMode ? irRxValid : serRxValid;
    assign rxInByte = irMode ? irRxByte : serRxByte;
    assign rxRoom = rxLevel < `USD_CFG_DEPTH;
    assign rxPush = fifoEnable && rxIn && rxRoom;
    assign rxPop = fifoEnable && rdAccept && rxFifoValid;
    assign headByte = fifoEnable ? rxFifoData : rxHold_reg;

    // A new byte wins over a read that empties the buffer in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxHold_reg <= `USD_DATA_RESET;
            rxHoldValid_reg <= 1'b0;
        end else if (!fifoEnable && rxIn) begin
            rxHold_reg <= rxInByte;
            rxHoldValid_reg <= 1'b1;
        end else if (!fifoEnable && rdAccept) begin
            rxHoldValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overrunPulse <= 1'b0;
        end else begin
            overrunPulse <= rxIn && (fifoEnable ? !rxRoom
                : (rxHoldValid_reg && !rdAccept));
        end
    end

    usd_fifo #(
        .WIDTH(8),
        .DEPTH(`USD_FIFO_WORDS)
    ) u_rx_fifo (
        .clk(clk),
        .rstn(rstn),
        .inValid(rxPush),
        .inData(rxInByte),
        .inReady(),
        .outValid(rxFifoValid),
        .outData(rxFifoData),
        .outReady(rxPop),
        .level(rxLevel)
    );

    // ****************************************************************
    // Bus answers
    // ****************************************************************
    // Read data are captured at the address phase so no wait state is needed.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= `USD_HRDATA_RESET;
        end else if (rdAccept) begin
            hrdata <= {`USD_UPPER_ZERO, headByte};
        end else if (hready) begin
            hrdata <= `USD_HRDATA_RESET;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************************************
    // Transmit path
    // ****************************************************************
    usd_byte_t wrByte;
    usd_byte_t txHold_reg;
    logic txHoldFull_reg;
    logic txFifoValid;
    usd_byte_t txFifoData;
    logic txFifoInReady;
    logic [`USD_LEVEL_W-1:0] txLevel;
    logic txPush;
    logic txPop;
    logic stageFree;
    logic holdTake;
    logic stageLoad;

    assign wrByte = hwdata[`USD_DATA_MSB:0];
    assign txPush = wrCommit && fifoEnable && txFifoInReady
        && (txLevel < `USD_CFG_DEPTH);
    assign stageFree = !(txSerValid || txIrValid) || txReady;
    assign txPop = stageFree && fifoEnable && txFifoValid;
    assign holdTake = stageFree && !fifoEnable && txHoldFull_reg;
    assign stageLoad = txPop || holdTake;

    // A write in the cycle the byte leaves keeps the register full.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txHold_reg <= `USD_DATA_RESET;
            txHoldFull_reg <= 1'b0;
        end else if (wrCommit && !fifoEnable) begin
            txHold_reg <= wrByte;
            txHoldFull_reg <= 1'b1;
        end else if (holdTake) begin
            txHoldFull_reg <= 1'b0;
        end
    end

    usd_fifo #(
        .WIDTH(8),
        .DEPTH(`USD_FIFO_WORDS)
    ) u_tx_fifo (
        .clk(clk),
        .rstn(rstn),
        .inValid(txPush),
        .inData(wrByte),
        .inReady(txFifoInReady),
        .outValid(txFifoValid),
        .outData(txFifoData),
        .outReady(txPop),
        .level(txLevel)
    );

    // The mode is sampled when a byte enters the stage and held with it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txByte <= `USD_DATA_RESET;
            txSerValid <= 1'b0;
            txIrValid <= 1'b0;
        end else if (stageLoad) begin
            txByte <= fifoEnable ? txFifoData : txHold_reg;
            txSerValid <= !irMode;
            txIrValid <= irMode;
        end else if (txReady) begin
            txSerValid <= 1'b0;
            txIrValid <= 1'b0;
        end
    end

    // ****************************************************************
    // Status
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxDataReady <= 1'b0;
            txHoldingEmpty <= 1'b1;
        end else begin
            rxDataReady <= fifoEnable ? rxFifoValid : rxHoldValid_reg;
            txHoldingEmpty <= fifoEnable ? (txLevel == '0)
                : !txHoldFull_reg;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_ALIAS_READ: assert property (
        rdAccept && !fifoEnable |=> hrdata[7:0] == $past(rxHold_reg))
        else $error("Aliased read did not return the receive buffer.");

    AST_RX_SOURCE: assert property (
        !fifoEnable && irMode && irRxValid ##1 !fifoEnable && !rxIn
        |=> rxDataReady && rxHold_reg == $past(irRxByte, 2))
        else $error("Infrared byte not taken into the receive buffer.");

    AST_RX_OVERWRITE: assert property (
        !fifoEnable && rxIn && rxHoldValid_reg && !rdAccept
        |=> overrunPulse && rxHold_reg == $past(rxInByte))
        else $error("Overwrite without overrun in non-FIFO mode.");

    AST_RX_POP: assert property (
        rxPop |=> hrdata == {`USD_UPPER_ZERO, $past(rxFifoData)}
            && rxLevel == $past(rxLevel) - 6'(1) + 6'($past(rxPush)))
        else $error("FIFO read did not return and pop the head.");

    AST_RX_FULL_DROP: assert property (
        fifoEnable && rxIn && rxLevel == `USD_CFG_DEPTH && !rxPop
        |=> overrunPulse && rxLevel == `USD_CFG_DEPTH)
        else $error("Full receive FIFO changed or missed overrun.");

    AST_TX_STEER: assert property (
        stageLoad |=> (txIrValid == $past(irMode))
            && (txSerValid == !$past(irMode)))
        else $error("Transmit byte sent to the wrong output.");

    AST_TX_HOLDING_EMPTY_CLEAR: assert property (
        wrCommit && !fifoEnable && !holdTake && txHoldingEmpty
        |=> txHoldFull_reg ##1 !txHoldingEmpty)
        else $error("Write did not clear holding empty.");

    AST_THR_REPLACE: assert property (
        wrCommit && !fifoEnable |=> txHold_reg == $past(hwdata[7:0]))
        else $error("Pending transmit byte not replaced.");

    AST_TX_ACCEPT: assert property (
        wrCommit && fifoEnable && txLevel < `USD_CFG_DEPTH && !txPop
        |=> txLevel == $past(txLevel) + 6'(1))
        else $error("Transmit FIFO refused a write below depth.");

    AST_TX_FULL_DROP: assert property (
        wrCommit && fifoEnable && txLevel == `USD_CFG_DEPTH && !txPop
        |=> txLevel == `USD_CFG_DEPTH)
        else $error("Write into a full transmit FIFO was stored.");

    AST_UPPER_ZERO: assert property (
        rdAccept |=> hrdata[31:8] == `USD_UPPER_ZERO)
        else $error("Upper data bits not zero.");

    COV_FIFO_READ: cover property (rxPop);
    COV_RX_OVERRUN: cover property (overrunPulse ##1 rdAccept);
    COV_TX_FULL: cover property (txPush ##[1:40] txLevel == `USD_CFG_DEPTH);
    COV_IR_SEND: cover property (stageLoad && irMode);
endmodule : usd_shadow_port

`default_nettype wire

// file: usd_shadow_port_tb.sv
// Purpose: Self-checking bench of the shadow data port.
// Assumes: Zero wait state slave; hready is fed back from hreadyout.
// Notes: Expected values wait in queues until the monitor sees results.
`include "usd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module usd_shadow_port_tb;
    import usd_pkg::*;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    usd_trans_t htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic fifoEnable = 1'b0;
    logic irMode = 1'b0;
    logic stall = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, serRxValid, irRxValid, txSerValid, txIrValid;
    logic txReady, rxDataReady, txHoldingEmpty, overrunPulse;
    logic takenValid, takenIr;
    usd_byte_t serRxByte, irRxByte, txByte, takenByte;
    int error_cnt = 0;
    int check_count = 0;
    int ovCnt = 0;
    logic rdPend = 1'b0;
    logic [31:0] seed = 32'h0000_0021;
    logic [31:0] expRd[$];
    logic [8:0] expTx[$];
    logic [8:0] txExp = 9'h000;

    always #25 clk = ~clk;

    usd_shadow_port i_dut (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fifoEnable(fifoEnable),
        .irMode(irMode), .serRxValid(serRxValid), .serRxByte(serRxByte),
        .irRxValid(irRxValid), .irRxByte(irRxByte), .txByte(txByte),
        .txSerValid(txSerValid), .txIrValid(txIrValid), .txReady(txReady),
        .rxDataReady(rxDataReady), .txHoldingEmpty(txHoldingEmpty),
        .overrunPulse(overrunPulse));

    usd_line_model i_line (.clk(clk), .rstn(rstn), .stall(stall),
        .serRxValid(serRxValid), .serRxByte(serRxByte),
        .irRxValid(irRxValid), .irRxByte(irRxByte), .txByte(txByte),
        .txSerValid(txSerValid), .txIrValid(txIrValid), .txReady(txReady),
        .takenValid(takenValid), .takenIr(takenIr), .takenByte(takenByte));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] aliasAddr();
        return `USD_SHADOW_BASE + (xs() & 32'h0000_003C);
    endfunction : aliasAddr

    function automatic logic pick(input int w);
        case (w)
            0: return rxDataReady;
            1: return txHoldingEmpty;
            3: return hreadyout;
            default: return expTx.size() == 0;
        endcase
    endfunction : pick

    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // A hang ends the run here rather than stalling the simulator.
    task automatic waitSig(input int w, input logic lvl);
        for (int n = 0; n < 300; n++) begin
            if (pick(w) === lvl) begin
                return;
            end
            @(posedge clk);
        end
        chk("wait bound", 32'h0000_0000, 32'h0000_0001);
        final_report();
    endtask : waitSig

    task automatic busXfer(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        waitSig(3, 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        waitSig(3, 1'b1);
    endtask : busXfer

    task automatic drain();
        waitSig(4, 1'b1);
        repeat (10) @(posedge clk);
    endtask : drain

    always @(posedge clk) begin
        if (overrunPulse === 1'b1) begin
            ovCnt++;
        end
        if (rdPend) begin
            chk("hrdata", hrdata, expRd.pop_front());
            chk("hresp", {31'h0, hresp}, 32'h0000_0000);
            chk("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
        end
        if (takenValid === 1'b1 && expTx.size() == 0) begin
            chk("extra tx", 32'h0000_0001, 32'h0000_0000);
        end else if (takenValid === 1'b1) begin
            txExp = expTx.pop_front();
            chk("tx", {23'h0, takenIr, takenByte}, {23'h0, txExp});
        end
        rdPend = hsel && htrans[1] && !hwrite && hreadyout;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [31:0] w;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("empty", {31'h0, txHoldingEmpty}, 32'h0000_0001);
        chk("ready", {31'h0, rxDataReady}, 32'h0000_0000);
        for (int m = 0; m < 2; m++) begin
            irMode <= m[0];
            w = xs();
            i_line.send(w[7:0], m[0], 1'b0);
            waitSig(0, 1'b1);
            expRd.push_back({24'h0, w[7:0]});
            busXfer(1'b0, m ? `USD_SHADOW6_ADDR : aliasAddr(), xs());
            waitSig(0, 1'b0);
        end
        i_line.send(8'h5A, 1'b1, 1'b1);
        i_line.send(8'hA5, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk("overruns", ovCnt, 32'h0000_0001);
        expRd.push_back(32'h0000_00A5);
        busXfer(1'b0, aliasAddr(), xs());
        waitSig(0, 1'b0);
        fifoEnable <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            w = xs();
            if (i < 16) begin
                expRd.push_back({24'h0, w[7:0]});
            end
            i_line.send(w[7:0], 1'b1, i < 16);
        end
        repeat (4) @(posedge clk);
        chk("overruns", ovCnt, 32'h0000_0002);
        for (int i = 0; i < 16; i++) begin
            waitSig(0, 1'b1);
            busXfer(1'b0, aliasAddr(), xs());
        end
        waitSig(0, 1'b0);
        // The first byte parks in the stalled stage; a later write replaces the one held.
        fifoEnable <= 1'b0;
        irMode <= 1'b0;
        stall <= 1'b1;
        waitSig(1, 1'b1);
        w = xs();
        expTx.push_back({1'b0, w[7:0]});
        busXfer(1'b1, aliasAddr(), w);
        repeat (3) @(posedge clk);
        busXfer(1'b1, aliasAddr(), xs());
        repeat (3) @(posedge clk);
        chk("empty", {31'h0, txHoldingEmpty}, 32'h0000_0000);
        w = xs();
        expTx.push_back({1'b0, w[7:0]});
        busXfer(1'b1, aliasAddr(), w);
        stall <= 1'b0;
        drain();
        chk("empty", {31'h0, txHoldingEmpty}, 32'h0000_0001);
        irMode <= 1'b1;
        fifoEnable <= 1'b1;
        stall <= 1'b1;
        for (int i = 0; i < 18; i++) begin
            w = xs();
            if (i < 17) begin
                expTx.push_back({1'b1, w[7:0]});
            end
            busXfer(1'b1, aliasAddr(), w);
            if (i == 0) begin
                repeat (6) @(posedge clk);
            end
        end
        chk("empty", {31'h0, txHoldingEmpty}, 32'h0000_0000);
        stall <= 1'b0;
        drain();
        busXfer(1'b1, 32'h5000_1070, xs());
        expRd.push_back(32'h0000_0000);
        busXfer(1'b0, 32'h5000_102C, xs());
        drain();
        final_report();
    end
endmodule : usd_shadow_port_tb

`default_nettype wire
